// [rtl/cpg_defines.vh]
// constants for the peripheral bus interface and its indexed register file
`ifndef CPG_DEFINES_VH
`define CPG_DEFINES_VH
`define CPG_IDX_W        3
`define CPG_NUM_REGS     8
`define CPG_IDX_CONFIG   3'h0
`define CPG_IDX_VECTOR   3'h1
`define CPG_IDX_STATUS   3'h2
`define CPG_IDX_COMMAND  3'h3
`define CPG_CFG_RESET    8'h00
`define CPG_VEC_RESET    8'h00
`define CPG_BIT_IRQ_EN   0
`define CPG_BIT_CLR_IP   0
`define CPG_BIT_CLR_IUS  1
`define CPG_ST_INDEX     1'b0
`define CPG_ST_DATA      1'b1
`define CPG_SEL_CONTROL  1'b0
`define CPG_SEL_DATA     1'b1
`define CPG_SYNC_W       14
`endif

// [rtl/cpg_sync.v]
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module cpg_sync
#(
   parameter W         = 14,
   parameter RESET_VAL = 14'h3fff
)
(
   // clock and reset
   input  wire         clk_i,
   input  wire         rst_i,
   // pins in, synchronised out
   input  wire [W-1:0] async_i,
   output wire [W-1:0] sync_o
);

reg [W-1:0] meta_q;
reg [W-1:0] sync_q;

always @(posedge clk_i or posedge rst_i)
begin
   if (rst_i)
   begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
   end
   else
   begin
      meta_q <= async_i;
      sync_q <= meta_q;
   end
end

assign sync_o = sync_q;

endmodule

// [rtl/cpg_periph_if.v]
// bus interface of an 8-bit peripheral: indexed control port, direct data port, interrupt chain
// Functional notes
// - control-port writes alternate between index and data
// - data register reached by one direct read or write
// - read and write strobes low together reset the peripheral
// - read strobe fall during acknowledge sets in-service and drives vector
`timescale 1ns/1ps
`include "cpg_defines.vh"
module cpg_periph_if
(
   // clock and reset
   input  wire       clk_i,
   input  wire       rst_i,
   // bus pins from the glue logic
   input  wire       chip_enable_n_i,
   input  wire       rd_n_i,
   input  wire       wr_n_i,
   input  wire       register_select_i,
   input  wire [7:0] data_i,
   output wire [7:0] data_o,
   output wire       data_oe_n_o,
   // interrupt pins
   input  wire       irq_acknowledge_n_i,
   input  wire       prio_chain_in_i,
   output wire       prio_chain_out_o,
   output wire       irq_n_o,
   output wire       irq_oe_n_o,
   // user side
   input  wire [7:0] rx_data_i,
   output wire [7:0] tx_data_o,
   output wire       tx_valid_o,
   output wire       rx_taken_o,
   input  wire       irq_event_i,
   output wire       in_service_bit_o,
   output wire       soft_reset_o
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisation: every pin passes two flops before use

wire [`CPG_SYNC_W-1:0] pins_s;
wire                   ce_n_s;
wire                   rd_n_s;
wire                   wr_n_s;
wire                   sel_s;
wire                   ack_n_s;
wire                   chain_in_s;
wire [7:0]             data_s;

cpg_sync #(
   .W         (`CPG_SYNC_W),
   .RESET_VAL ({`CPG_SYNC_W{1'b1}})
) u_sync (
   .clk_i   (clk_i),
   .rst_i   (rst_i),
   .async_i ({chip_enable_n_i, rd_n_i, wr_n_i, register_select_i,
              irq_acknowledge_n_i, prio_chain_in_i, data_i}),
   .sync_o  (pins_s)
);

assign {ce_n_s, rd_n_s, wr_n_s, sel_s, ack_n_s, chain_in_s, data_s} = pins_s;

////////////////////////////////////////////////////////////////////////////////
// strobe edges and combined reset

reg  rd_n_prev_q;
reg  wr_n_prev_q;
wire soft_rst  = ~rd_n_s & ~wr_n_s;
// both strobes low is a reset, never an access
wire rd_fall   = rd_n_prev_q & ~rd_n_s & wr_n_s;
wire wr_fall   = wr_n_prev_q & ~wr_n_s & rd_n_s;
wire ack_cycle = ~ack_n_s;
wire bus_rd    = rd_fall & ~ce_n_s & ~ack_cycle;
wire bus_wr    = wr_fall & ~ce_n_s & ~ack_cycle;

always @(posedge clk_i or posedge rst_i)
begin
   if (rst_i)
   begin
      rd_n_prev_q <= 1'b1;
      wr_n_prev_q <= 1'b1;
   end
   else
   begin
      rd_n_prev_q <= rd_n_s;
      wr_n_prev_q <= wr_n_s;
   end
end

////////////////////////////////////////////////////////////////////////////////
// indexed register file behind the control port

reg [7:0]            regs_q [0:`CPG_NUM_REGS-1];
reg                  state_q;
reg [`CPG_IDX_W-1:0] index_q;
reg                  ip_q;
reg                  ius_q;
reg [7:0]            data_q;
reg                  drive_q;
reg                  vec_q;
reg [7:0]            tx_q;
reg                  tx_valid_q;
reg                  rx_taken_q;

wire [7:0] status_w = {6'h00, ius_q, ip_q};
wire       ctl_wr   = bus_wr & (sel_s == `CPG_SEL_CONTROL);
wire       idx_wr   = ctl_wr & (state_q == `CPG_ST_INDEX);
wire       val_wr   = ctl_wr & (state_q == `CPG_ST_DATA);
wire       cmd_wr   = val_wr & (index_q == `CPG_IDX_COMMAND);
wire       irq_en   = regs_q[`CPG_IDX_CONFIG][`CPG_BIT_IRQ_EN];
// acknowledge only taken by the device at the head of the chain with a request
wire       ack_take = rd_fall & ack_cycle & chain_in_s & ip_q & ~ius_q;

function [7:0] read_mux;
   input [`CPG_IDX_W-1:0] idx;
   input [7:0]            stat;
   input [7:0]            cfg;
   input [7:0]            vec;
   begin
      case (idx)
         `CPG_IDX_CONFIG: read_mux = cfg;
         `CPG_IDX_VECTOR: read_mux = vec;
         `CPG_IDX_STATUS: read_mux = stat;
         default:         read_mux = 8'h00;
      endcase
   end
endfunction

integer i;

always @(posedge clk_i or posedge rst_i)
begin
   if (rst_i)
   begin
      for (i = 0; i < `CPG_NUM_REGS; i = i + 1)
         regs_q[i] <= 8'h00;
      state_q    <= `CPG_ST_INDEX;
      index_q    <= {`CPG_IDX_W{1'b0}};
      ip_q       <= 1'b0;
      ius_q      <= 1'b0;
      data_q     <= 8'h00;
      drive_q    <= 1'b0;
      vec_q      <= 1'b0;
      tx_q       <= 8'h00;
      tx_valid_q <= 1'b0;
      rx_taken_q <= 1'b0;
   end
   else if (soft_rst)
   begin
      regs_q[`CPG_IDX_CONFIG] <= `CPG_CFG_RESET;
      regs_q[`CPG_IDX_VECTOR] <= `CPG_VEC_RESET;
      state_q    <= `CPG_ST_INDEX;
      index_q    <= {`CPG_IDX_W{1'b0}};
      ip_q       <= 1'b0;
      ius_q      <= 1'b0;
      drive_q    <= 1'b0;
      vec_q      <= 1'b0;
      tx_valid_q <= 1'b0;
      rx_taken_q <= 1'b0;
   end
   else
   begin
      tx_valid_q <= 1'b0;
      rx_taken_q <= 1'b0;
      // index and value writes alternate; a control read also rearms the index step
      if (idx_wr)
      begin
         index_q <= data_s[`CPG_IDX_W-1:0];
         state_q <= `CPG_ST_DATA;
      end
      else if (val_wr)
      begin
         if (~cmd_wr && index_q != `CPG_IDX_STATUS)
            regs_q[index_q] <= data_s;
         state_q <= `CPG_ST_INDEX;
      end
      else if (bus_rd && sel_s == `CPG_SEL_CONTROL)
         state_q <= `CPG_ST_INDEX;
      // direct data port needs no index step
      if (bus_wr && sel_s == `CPG_SEL_DATA)
      begin
         tx_q       <= data_s;
         tx_valid_q <= 1'b1;
      end
      if (bus_rd)
      begin
         if (sel_s == `CPG_SEL_DATA)
         begin
            data_q     <= rx_data_i;
            rx_taken_q <= 1'b1;
         end
         else
            data_q <= read_mux(index_q, status_w, regs_q[`CPG_IDX_CONFIG], regs_q[`CPG_IDX_VECTOR]);
      end
      // event sets pending; a set in the same cycle as a clear wins
      if (irq_event_i)
         ip_q <= 1'b1;
      else if (ack_take || (cmd_wr && data_s[`CPG_BIT_CLR_IP]))
         ip_q <= 1'b0;
      if (ack_take)
      begin
         ius_q  <= 1'b1;
         data_q <= regs_q[`CPG_IDX_VECTOR];
         vec_q  <= 1'b1;
      end
      else if (cmd_wr && data_s[`CPG_BIT_CLR_IUS])
         ius_q <= 1'b0;
      // data lines driven while the strobe stays low, and for a bus read while chip enable also stays low
      if (bus_rd || ack_take)
         drive_q <= 1'b1;
      else if (rd_n_s || (ce_n_s && ~vec_q))
      begin
         drive_q <= 1'b0;
         vec_q   <= 1'b0;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// outputs

assign data_o           = data_q;
assign data_oe_n_o      = ~drive_q;
// the chain is blocked while serviced, or while a request waits in acknowledge
assign prio_chain_out_o = chain_in_s & ~ius_q & ~(ip_q & ack_cycle);
// open drain request: pin pulled low only while enabled
assign irq_n_o          = 1'b0;
assign irq_oe_n_o       = ~(ip_q & irq_en & ~ius_q & chain_in_s);
assign tx_data_o        = tx_q;
assign tx_valid_o       = tx_valid_q;
assign rx_taken_o       = rx_taken_q;
assign in_service_bit_o = ius_q;
assign soft_reset_o     = soft_rst;

endmodule

// [tb/cpg_periph_if_sva.sv]
// assertions on the peripheral bus interface pins
`timescale 1ns/1ps
module cpg_periph_if_sva
(
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // bus pins
   input wire chip_enable_n_i,
   input wire rd_n_i,
   input wire wr_n_i,
   input wire register_select_i,
   input wire irq_acknowledge_n_i,
   // watched outputs
   input wire data_oe_n_o,
   input wire tx_valid_o,
   input wire in_service_bit_o,
   input wire soft_reset_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   property p_wr_direct;
      $fell(wr_n_i) && !chip_enable_n_i && register_select_i && rd_n_i && irq_acknowledge_n_i |-> ##[2:5] tx_valid_o;
   endproperty
   a_wr_direct: assert property (p_wr_direct) else $error("no tx pulse");
   // drive must end within a sync delay of the strobe going high
   property p_rd_drive;
      !data_oe_n_o |-> !($past(rd_n_i, 2) && $past(rd_n_i, 3) && $past(rd_n_i, 4));
   endproperty
   a_rd_drive: assert property (p_rd_drive) else $error("data driven without read");
   property p_soft;
      (!rd_n_i && !wr_n_i) [*3] |-> soft_reset_o;
   endproperty
   a_soft: assert property (p_soft) else $error("no soft reset");
   property p_ius_set;
      $rose(in_service_bit_o) |-> !$past(irq_acknowledge_n_i, 2) && !$past(rd_n_i, 2);
   endproperty
   a_ius_set: assert property (p_ius_set) else $error("in-service set outside acknowledge");
endmodule
bind cpg_periph_if cpg_periph_if_sva u_sva (.*);

// [tb/cpg_host.sv]
// glue-side model that drives the peripheral bus pins
`timescale 1ns/1ps
module cpg_host
(
   // clock
   input  wire       clk_i,
   // pins to the peripheral, changed on falling edges only
   output reg        ce_n_o  = 1'b1,
   output reg        rd_n_o  = 1'b1,
   output reg        wr_n_o  = 1'b1,
   output reg        sel_o   = 1'b0,
   output reg  [7:0] dat_o   = 8'h00,
   output reg        ack_n_o = 1'b1,
   output reg        chain_o = 1'b1,
   input  wire [7:0] dat_i
);
   // strobes stay low 6 cycles so two sync flops plus the take land inside
   task cyc(input rd, input s, input ce, input [7:0] d, output [7:0] q);
   begin
      sel_o = s;
      ce_n_o = ce;
      dat_o = d;
      @(negedge clk_i);
      rd_n_o = !rd;
      wr_n_o = rd;
      repeat (6) @(negedge clk_i);
      q = dat_i;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      ce_n_o = 1'b1;
      dat_o = ~d;
      repeat (3) @(negedge clk_i);
   end
   endtask
   task irq_acknowledge_n(output [7:0] q);
   begin
      ack_n_o = 1'b0;
      repeat (3) @(negedge clk_i);
      rd_n_o = 1'b0;
      repeat (6) @(negedge clk_i);
      q = dat_i;
      rd_n_o = 1'b1;
      ack_n_o = 1'b1;
      repeat (3) @(negedge clk_i);
   end
   endtask
   task hwreset;
   begin
      rd_n_o = 1'b0;
      wr_n_o = 1'b0;
      repeat (4) @(negedge clk_i);
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      repeat (3) @(negedge clk_i);
   end
   endtask
endmodule

// [tb/cpu_to_peripheral_glue_tb.sv]
// self-checking bench for the peripheral bus interface
`timescale 1ns/1ps
module cpu_to_peripheral_glue_tb;
   reg         clk_i = 1'b0;
   reg         rst_i = 1'b1;
   reg   [7:0] rx    = 8'h00;
   reg         ev    = 1'b0;
   wire        ce_n, rd_n, wr_n, sel, ack_n, chain, oe_n, irq_oe_n, tx_v, in_service_bit, chain_out, rx_tk;
   wire  [7:0] wd, rd_q, tx;
   // released data lines float up to the pull-up level, so a missing drive shows as ff
   wire  [7:0] bus_q = oe_n ? 8'hff : rd_q;
   reg   [7:0] q;
   reg  [25:0] rows [0:3];
   integer     n_fail = 0;
   integer     checks_done = 0;
   integer     n_tx = 0;
   integer     n_rx = 0;
   integer     ticks = 0;
   integer     i;
   always #12.5 clk_i = ~clk_i;
   cpg_host host (.clk_i(clk_i), .ce_n_o(ce_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .sel_o(sel), .dat_o(wd),
                  .ack_n_o(ack_n), .chain_o(chain), .dat_i(bus_q));
   cpg_periph_if dut (.clk_i(clk_i), .rst_i(rst_i), .chip_enable_n_i(ce_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
                      .register_select_i(sel), .data_i(wd), .data_o(rd_q), .data_oe_n_o(oe_n),
                      .irq_acknowledge_n_i(ack_n), .prio_chain_in_i(chain), .prio_chain_out_o(chain_out),
                      .irq_n_o(), .irq_oe_n_o(irq_oe_n), .rx_data_i(rx), .tx_data_o(tx), .tx_valid_o(tx_v),
                      .rx_taken_o(rx_tk), .irq_event_i(ev), .in_service_bit_o(in_service_bit), .soft_reset_o());
   ////////////////////////////////////////////////////////////
   task check(input [7:0] got, input [7:0] exp);
   begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
         n_fail = n_fail + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task results;
   begin
      $display("checks %0d fails %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   // the whole run needs well under 1000 cycles
   always @(posedge clk_i)
   begin
      ticks <= ticks + 1;
      if (tx_v === 1'b1)
         n_tx <= n_tx + 1;
      if (rx_tk === 1'b1)
         n_rx <= n_rx + 1;
      if (ticks == 3000)
      begin
         n_fail = n_fail + 1;
         results;
      end
   end
   initial
   begin
      // read, ce_n, value, expected byte, tx pulses so far
      rows[0] = {1'b0, 1'b0, 8'h5a, 8'h5a, 8'h01};
      rows[1] = {1'b0, 1'b0, 8'ha5, 8'ha5, 8'h02};
      rows[2] = {1'b0, 1'b1, 8'h3c, 8'ha5, 8'h02};
      rows[3] = {1'b1, 1'b0, 8'hc3, 8'hc3, 8'h02};
      repeat (3) @(negedge clk_i);
      rst_i = 1'b0;
      for (i = 0; i < 4; i = i + 1)
      begin
         rx = rows[i][23:16];
         host.cyc(rows[i][25], 1'b1, rows[i][24], rows[i][23:16], q);
         check(rows[i][25] ? q : tx, rows[i][15:8]);
         check(n_tx[7:0], rows[i][7:0]);
      end
      check(n_rx[7:0], 8'h01);
      $display("direct port test done");
      host.cyc(1'b0, 1'b0, 1'b0, 8'h00, q);
      host.cyc(1'b0, 1'b0, 1'b0, 8'h01, q);
      host.cyc(1'b0, 1'b0, 1'b0, 8'h01, q);
      host.cyc(1'b0, 1'b0, 1'b0, 8'h7e, q);
      host.cyc(1'b0, 1'b0, 1'b0, 8'h00, q);
      host.cyc(1'b1, 1'b0, 1'b0, 8'h00, q);
      check(q, 8'h01);
      $display("indexed access test done");
      ev = 1'b1;
      @(negedge clk_i);
      ev = 1'b0;
      repeat (2) @(negedge clk_i);
      check({7'h00, irq_oe_n}, 8'h00);
      check({7'h00, chain_out}, 8'h01);
      host.irq_acknowledge_n(q);
      check(q, 8'h7e);
      check({7'h00, in_service_bit}, 8'h01);
      check({7'h00, chain_out}, 8'h00);
      $display("interrupt test done");
      host.hwreset;
      check({7'h00, in_service_bit}, 8'h00);
      host.cyc(1'b0, 1'b0, 1'b0, 8'h00, q);
      host.cyc(1'b1, 1'b0, 1'b0, 8'h00, q);
      check(q, 8'h00);
      $display("soft reset test done");
      // vector register was cleared by the strobe reset, so the acknowledge returns zero
      ev = 1'b1;
      @(negedge clk_i);
      ev = 1'b0;
      host.irq_acknowledge_n(q);
      check(q, 8'h00);
      host.cyc(1'b0, 1'b0, 1'b0, 8'h02, q);
      host.cyc(1'b1, 1'b0, 1'b0, 8'h00, q);
      check(q, 8'h02);
      ev = 1'b1;
      @(negedge clk_i);
      ev = 1'b0;
      host.cyc(1'b0, 1'b0, 1'b0, 8'h03, q);
      host.cyc(1'b0, 1'b0, 1'b0, 8'h03, q);
      check({7'h00, in_service_bit}, 8'h00);
      check({7'h00, chain_out}, 8'h01);
      host.cyc(1'b0, 1'b0, 1'b0, 8'h02, q);
      host.cyc(1'b1, 1'b0, 1'b0, 8'h00, q);
      check(q, 8'h00);
      $display("status and command test done");
      results;
   end
endmodule
